// file: hw/pwo_output_stage.sv
// Behaviour
// - rate select 0 gives single switch rate, 1 gives double switch rate
// - double rate enables the modulator interpolation filter
// - config writes are dropped unless global power-down is 1
// - pair1 select sets A1 and B1 half-bridge at 0, full-bridge at 1
// - pair2 select sets A2 and B2 half-bridge at 0, full-bridge at 1
// - third A select governs channel A3 alone
// - third B select governs channel B3 alone
// - half-bridge channel: minus leg runs at 0, disabled at 1
// - minus-leg disable ignored for full-bridge channels
// - one minus-leg disable setting covers all half-bridge channels
// - minimum pulse is setting times master clock period, zero means none
// - minimum pulse applies to plus and minus of every channel
// - leg skew delays minus after plus by setting master clock periods
// - pair skew delays each A pair after its B pair
`timescale 1ns/10ps
`default_nettype none
module pwo_output_stage
	import pwo_pkg::*;
#(
	parameter int CHANNELS = PWO_CHANNELS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic global_power_down,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_ff,
	input wire logic [CHANNELS-1:0] mod_pwm_in,
	output logic [CHANNELS-1:0] bridge_output_plus_ff,
	output logic [CHANNELS-1:0] bridge_output_minus_ff,
	output logic double_rate_ff,
	output logic interp_enable_ff
);
	pwo_cfg_type reg_cfg_ff, nxt_reg_cfg;
	pwo_cfg_type act_cfg_ff, nxt_act_cfg;
	logic [7:0] nxt_rdata;
	logic [7:0] cfg_byte, min_byte, dly_byte;
	logic [CHANNELS-1:0] nxt_plus, nxt_minus;
	logic [CHANNELS-1:0] full_bridge;
	logic nxt_double, nxt_interp;

	// register images, reserved bits read as zero
	always_comb begin
		cfg_byte = PWO_ZERO_BYTE;
		cfg_byte[PWO_BIT_OVERSAMPLE_RATE_SELECT] = reg_cfg_ff.oversample_rate_select;
		cfg_byte[PWO_BIT_PAIR1] = reg_cfg_ff.pair1_bridge_select;
		cfg_byte[PWO_BIT_PAIR2] = reg_cfg_ff.pair2_bridge_select;
		cfg_byte[PWO_BIT_A3] = reg_cfg_ff.ch_a_third_bridge_select;
		cfg_byte[PWO_BIT_B3] = reg_cfg_ff.ch_b_third_bridge_select;
		min_byte = PWO_ZERO_BYTE;
		min_byte[PWO_BIT_MINUS_DIS] = reg_cfg_ff.minus_leg_disable;
		min_byte[PWO_MIN_PULSE_LSB +: PWO_MIN_PULSE_W] = reg_cfg_ff.min_pulse;
		dly_byte = PWO_ZERO_BYTE;
		dly_byte[PWO_LEG_LSB +: PWO_LEG_W] = reg_cfg_ff.leg_skew_setting;
		dly_byte[PWO_PAIR_LSB +: PWO_PAIR_W] = reg_cfg_ff.pair_skew_setting;
	end

	// register writes and reads
	always_comb begin
		nxt_reg_cfg = reg_cfg_ff;
		nxt_rdata = reg_rdata_ff;
		// writes outside power-down are silently lost; software must set it first
		if (reg_wr && global_power_down) begin
			unique case (reg_addr)
				PWO_ADDR_CONFIG: begin
					nxt_reg_cfg.oversample_rate_select = reg_wdata[PWO_BIT_OVERSAMPLE_RATE_SELECT];
					nxt_reg_cfg.pair1_bridge_select = reg_wdata[PWO_BIT_PAIR1];
					nxt_reg_cfg.pair2_bridge_select = reg_wdata[PWO_BIT_PAIR2];
					nxt_reg_cfg.ch_a_third_bridge_select = reg_wdata[PWO_BIT_A3];
					nxt_reg_cfg.ch_b_third_bridge_select = reg_wdata[PWO_BIT_B3];
				end
				PWO_ADDR_MIN_PULSE: begin
					nxt_reg_cfg.minus_leg_disable = reg_wdata[PWO_BIT_MINUS_DIS];
					nxt_reg_cfg.min_pulse = reg_wdata[PWO_MIN_PULSE_LSB +: PWO_MIN_PULSE_W];
				end
				PWO_ADDR_DELAY: begin
					nxt_reg_cfg.leg_skew_setting = reg_wdata[PWO_LEG_LSB +: PWO_LEG_W];
					nxt_reg_cfg.pair_skew_setting = reg_wdata[PWO_PAIR_LSB +: PWO_PAIR_W];
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				PWO_ADDR_CONFIG: nxt_rdata = cfg_byte;
				PWO_ADDR_MIN_PULSE: nxt_rdata = min_byte;
				PWO_ADDR_DELAY: nxt_rdata = dly_byte;
				default: nxt_rdata = PWO_ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_cfg_ff <= PWO_CFG_RESET;
			reg_rdata_ff <= PWO_ZERO_BYTE;
		end else if (ce) begin
			reg_cfg_ff <= nxt_reg_cfg;
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// working copy follows the registers only in power-down, so a running
	// modulator never sees a setting change mid-stream
	always_comb begin
		nxt_act_cfg = act_cfg_ff;
		if (global_power_down) begin
			nxt_act_cfg = reg_cfg_ff;
		end
		nxt_double = act_cfg_ff.oversample_rate_select;
		nxt_interp = act_cfg_ff.oversample_rate_select;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			act_cfg_ff <= PWO_CFG_RESET;
			double_rate_ff <= 1'b0;
			interp_enable_ff <= 1'b0;
		end else if (ce) begin
			act_cfg_ff <= nxt_act_cfg;
			double_rate_ff <= nxt_double;
			interp_enable_ff <= nxt_interp;
		end
	end

	// channel order: A1 B1 A2 B2 A3 B3
	always_comb begin
		full_bridge = '0;
		full_bridge[0] = act_cfg_ff.pair1_bridge_select;
		full_bridge[1] = act_cfg_ff.pair1_bridge_select;
		full_bridge[2] = act_cfg_ff.pair2_bridge_select;
		full_bridge[3] = act_cfg_ff.pair2_bridge_select;
		full_bridge[4] = act_cfg_ff.ch_a_third_bridge_select;
		full_bridge[5] = act_cfg_ff.ch_b_third_bridge_select;
	end

	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		logic lvl_ff, nxt_lvl;
		logic [PWO_MIN_PULSE_W-1:0] cnt_ff, nxt_cnt;
		logic [PWO_HIST_DEPTH-1:0] hist_ff, nxt_hist;
		logic [PWO_PAIR_W:0] plus_tap, minus_tap;
		logic minus_on;

		// pulse filter: a level change is taken only once the present level
		// has lasted min_pulse cycles; shaping the source keeps both legs legal
		always_comb begin
			nxt_lvl = lvl_ff;
			nxt_cnt = cnt_ff;
			nxt_hist = {hist_ff[PWO_HIST_DEPTH-2:0], lvl_ff};
			if (global_power_down) begin
				nxt_lvl = 1'b0;
				nxt_cnt = '0;
				nxt_hist = '0;
			end else if (mod_pwm_in[c] != lvl_ff && cnt_ff >= act_cfg_ff.min_pulse) begin
				nxt_lvl = mod_pwm_in[c];
				nxt_cnt = PWO_MIN_PULSE_W'(1);
			end else if (cnt_ff != '1) begin
				nxt_cnt = cnt_ff + PWO_MIN_PULSE_W'(1);
			end
		end

		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				lvl_ff <= 1'b0;
				cnt_ff <= '0;
				hist_ff <= '0;
			end else if (ce) begin
				lvl_ff <= nxt_lvl;
				cnt_ff <= nxt_cnt;
				hist_ff <= nxt_hist;
			end
		end

		// even index is an A channel, delayed against its B partner
		always_comb begin
			plus_tap = '0;
			if (c % 2 == 0) begin
				plus_tap = {1'b0, act_cfg_ff.pair_skew_setting};
			end
			minus_tap = plus_tap + {3'b000, act_cfg_ff.leg_skew_setting};
			minus_on = full_bridge[c] || !act_cfg_ff.minus_leg_disable;
			nxt_plus[c] = !global_power_down && hist_ff[plus_tap];
			nxt_minus[c] = !global_power_down && minus_on && !hist_ff[minus_tap];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bridge_output_plus_ff <= '0;
			bridge_output_minus_ff <= '0;
		end else if (ce) begin
			bridge_output_plus_ff <= nxt_plus;
			bridge_output_minus_ff <= nxt_minus;
		end
	end
endmodule
`default_nettype wire

// file: hw/pwo_pkg.sv
package pwo_pkg;
	localparam int PWO_CHANNELS = 6;
	localparam logic [7:0] PWO_ADDR_CONFIG = 8'h31;
	localparam logic [7:0] PWO_ADDR_MIN_PULSE = 8'h32;
	localparam logic [7:0] PWO_ADDR_DELAY = 8'h33;
	localparam logic [7:0] PWO_CONFIG_RESET = 8'h00;
	localparam logic [7:0] PWO_MIN_PULSE_RESET = 8'h00;
	localparam logic [7:0] PWO_DELAY_RESET = 8'h00;
	localparam int PWO_BIT_OVERSAMPLE_RATE_SELECT = 7;
	localparam int PWO_BIT_PAIR1 = 4;
	localparam int PWO_BIT_PAIR2 = 3;
	localparam int PWO_BIT_A3 = 2;
	localparam int PWO_BIT_B3 = 1;
	localparam int PWO_BIT_MINUS_DIS = 7;
	localparam int PWO_MIN_PULSE_LSB = 0;
	localparam int PWO_MIN_PULSE_W = 5;
	localparam int PWO_LEG_LSB = 5;
	localparam int PWO_LEG_W = 3;
	localparam int PWO_PAIR_LSB = 0;
	localparam int PWO_PAIR_W = 5;
	localparam int PWO_HIST_DEPTH = 39;
	localparam logic [7:0] PWO_ZERO_BYTE = 8'h00;

	typedef struct packed {
		logic oversample_rate_select;
		logic pair1_bridge_select;
		logic pair2_bridge_select;
		logic ch_a_third_bridge_select;
		logic ch_b_third_bridge_select;
		logic minus_leg_disable;
		logic [PWO_MIN_PULSE_W-1:0] min_pulse;
		logic [PWO_LEG_W-1:0] leg_skew_setting;
		logic [PWO_PAIR_W-1:0] pair_skew_setting;
	} pwo_cfg_type;

	localparam pwo_cfg_type PWO_CFG_RESET = '0;
endpackage

// file: sim/pwo_output_stage_props.sv
`timescale 1ns/10ps
`default_nettype none
module pwo_output_stage_props
	import pwo_pkg::*;
#(parameter int CHANNELS = PWO_CHANNELS) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic global_power_down,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic [CHANNELS-1:0] mod_pwm_in,
	input wire logic [CHANNELS-1:0] bridge_output_plus_ff,
	input wire logic [CHANNELS-1:0] bridge_output_minus_ff,
	input wire logic double_rate_ff,
	input wire logic interp_enable_ff
);
	logic [CHANNELS-1:0] fb_ff;
	logic dis_ff;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_wr(a);
		reg_wr && global_power_down && reg_addr == a;
	endsequence
	// shadow of accepted writes, only the fields the minus-leg check needs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fb_ff <= '0;
			dis_ff <= 1'b0;
		end else if (reg_wr && global_power_down) begin
			if (reg_addr == PWO_ADDR_CONFIG)
				fb_ff <= {reg_wdata[1], reg_wdata[2], {2{reg_wdata[3]}}, {2{reg_wdata[4]}}};
			if (reg_addr == PWO_ADDR_MIN_PULSE)
				dis_ff <= reg_wdata[7];
		end
	end
	property p_rate;
		logic v;
		(s_wr(PWO_ADDR_CONFIG), v = reg_wdata[7]) ##1 global_power_down [*3]
			|-> double_rate_ff == v;
	endproperty
	property p_keep;
		logic [7:0] v;
		(s_wr(PWO_ADDR_MIN_PULSE), v = reg_wdata) ##2
			(reg_rd && !reg_wr && reg_addr == PWO_ADDR_MIN_PULSE) |=> reg_rdata_ff == (v & 8'h9f);
	endproperty
	interp_equal_a: assert property (interp_enable_ff == double_rate_ff)
		else $error("interp enable differs from rate");
	pdn_quiet_a: assert property (global_power_down && $past(global_power_down)
		|-> bridge_output_plus_ff == '0 && bridge_output_minus_ff == '0) else $error("outputs live");
	rate_hold_a: assert property (!global_power_down [*4] |-> $stable(double_rate_ff))
		else $error("rate moved while running");
	interp_hold_a: assert property (!global_power_down [*4] |-> $stable(interp_enable_ff))
		else $error("filter moved while running");
	rate_follow_a: assert property (p_rate) else $error("rate not taken");
	reg_keep_a: assert property (p_keep) else $error("readback wrong");
	unmapped_zero_a: assert property (reg_rd && reg_addr < PWO_ADDR_CONFIG |=>
		reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
	minus_off_a: assert property (!global_power_down [*4] ##0 dis_ff |->
		(bridge_output_minus_ff & ~fb_ff) == '0) else $error("half-bridge minus leg active");
endmodule
bind pwo_output_stage pwo_output_stage_props #(.CHANNELS(CHANNELS)) u_props (.sys_clk, .rst,
	.ce, .global_power_down, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_ff,
	.mod_pwm_in, .bridge_output_plus_ff, .bridge_output_minus_ff, .double_rate_ff,
	.interp_enable_ff);
`default_nettype wire

// file: sim/pwo_bridge_model.sv
`timescale 1ns/10ps
`default_nettype none
module pwo_bridge_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic stage_on,
	input wire logic [5:0] leg_minus,
	output logic [5:0] seen_minus_ff
);
	// sticky per leg, cleared while the stage is off, so a dead leg shows as 0
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			seen_minus_ff <= 6'h00;
		else if (!stage_on)
			seen_minus_ff <= 6'h00;
		else
			seen_minus_ff <= seen_minus_ff | leg_minus;
	end
endmodule
`default_nettype wire

// file: sim/pwm_output_stage_config_test.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_output_stage_config_test
	import pwo_pkg::*;
;
	logic sys_clk = 1'b0, rst = 1'b1, pd = 1'b0, wr_s = 1'b0, rd_s = 1'b0, dbl, itp;
	logic [7:0] adr = 8'h00, wd = 8'h00, rdat;
	logic [5:0] pin = 6'h00, po, mo, seen;
	int n_errors = 0, checked = 0, cyc = 0, w, da, dl;
	pwo_output_stage dut (.sys_clk, .rst, .ce(1'b1), .global_power_down(pd), .reg_addr(adr),
		.reg_wr(wr_s), .reg_wdata(wd), .reg_rd(rd_s), .reg_rdata_ff(rdat), .mod_pwm_in(pin),
		.bridge_output_plus_ff(po), .bridge_output_minus_ff(mo), .double_rate_ff(dbl),
		.interp_enable_ff(itp));
	pwo_bridge_model stage (.sys_clk, .rst, .stage_on(!pd), .leg_minus(mo), .seen_minus_ff(seen));
	initial forever #25 sys_clk = ~sys_clk;
	task test_done;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{adr, wd, wr_s} = {a, d, 1'b1};
		@(negedge sys_clk);
		wr_s = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string s);
		@(negedge sys_clk);
		{adr, rd_s} = {a, 1'b1};
		@(negedge sys_clk);
		rd_s = 1'b0;
		@(negedge sys_clk);
		chk(s, e, rdat);
	endtask
	// settings only land while powered down, so every change goes through here
	task cfg(input logic [7:0] c, input logic [7:0] m, input logic [7:0] d);
		pd = 1'b1;
		wr(PWO_ADDR_CONFIG, c);
		wr(PWO_ADDR_DELAY, d);
		wr(PWO_ADDR_MIN_PULSE, m);
		rd(PWO_ADDR_MIN_PULSE, m & 8'h9f, "minp");
		repeat (4) @(negedge sys_clk);
		pd = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask
	task pulse;
		int ta, tb, tm;
		ta = -1;
		tb = -1;
		tm = -1;
		w = 0;
		pin = 6'h03;
		for (int i = 0; i < 60; i++) begin
			@(negedge sys_clk);
			if (i == 1) pin = 6'h00;
			w += po[1];
			if (po[0] && ta < 0) ta = i;
			if (po[1] && tb < 0) tb = i;
			if (!mo[1] && tb >= 0 && tm < 0) tm = i;
		end
		da = ta - tb;
		dl = tm - tb;
	endtask
	task t_reg;
		wr(PWO_ADDR_CONFIG, 8'h80);
		rd(PWO_ADDR_CONFIG, 8'h00, "lock");
		rd(PWO_ADDR_DELAY, 8'h00, "dly");
		pd = 1'b1;
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00, "unmap");
	endtask
	task t_bridge;
		cfg(8'hd5, 8'he0, 8'h00);
		rd(PWO_ADDR_CONFIG, 8'h94, "cfg");
		chk("dbl", 8'h01, {7'h00, dbl});
		chk("itp", 8'h01, {7'h00, itp});
		repeat (20) @(negedge sys_clk) pin = ~pin;
		pin = 6'h00;
		repeat (90) @(negedge sys_clk);
		chk("minus", 8'h13, {2'b00, seen});
	endtask
	task t_timing;
		cfg(8'h00, 8'h00, 8'h43);
		chk("sgl", 8'h00, {7'h00, dbl});
		pulse;
		chk("w0", 8'h02, 8'(w));
		chk("pair", 8'h03, 8'(da));
		chk("leg", 8'h02, 8'(dl));
		cfg(8'h00, 8'h06, 8'h00);
		// the idle low level must itself last the minimum before a rise is taken
		repeat (8) @(negedge sys_clk);
		pulse;
		chk("w6", 8'h01, {7'h00, w >= 6 && w <= 7});
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		t_reg;
		t_bridge;
		t_timing;
		test_done;
	end
endmodule
`default_nettype wire
